// ===== src/exception_vector_address_unit.sv
`timescale 1ns/10ps
`include "exc_vec_cfg.svh"

module exception_vector_address_unit
	import exc_vec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// core references and events
	input  wire logic        core_ref_req,
	input  wire logic        core_ref_write,
	input  wire logic        core_ref_program,
	input  wire logic [23:0] core_ref_addr,
	input  wire logic        instr_boundary,
	input  wire logic        instr_done,
	input  wire logic        soft_reset,
	input  wire logic        odd_fetch,
	input  wire logic        bus_fault,
	input  wire logic        illegal_op,
	input  wire logic        unimpl_op,
	input  wire logic [3:0]  opcode_top,
	input  wire logic        priv_violation,
	input  wire logic        format_error,
	input  wire logic        zero_divide,
	input  wire logic        bounds_fail,
	input  wire logic        overflow_trap,
	input  wire logic        trap_req,
	input  wire logic [3:0]  trap_num,
	// context save handshake with the core
	input  wire logic        save_done,
	// bus controller, same clock
	input  wire logic        bus_done,
	input  wire logic        bus_error,
	input  wire logic [15:0] bus_rdata,
	// pins
	input  wire logic [2:0]  irq_level,
	input  wire logic        autovector,
	// outputs
	output bus_out_t         bus,
	output logic             save_req,
	output logic             exc_active,
	output logic             halted,
	output logic [7:0]       vector_number,
	output logic             vector_valid,
	output logic [31:0]      vector_address,
	output logic [15:0]      status,
	output logic [15:0]      status_copy,
	output logic             resume,
	output logic             load_ssp,
	output logic [31:0]      new_pc,
	output logic [31:0]      new_ssp
);

	localparam regs_t RESET_STATE = '{
		phase   : PH_IDLE,
		sr      : `SR_RESET,
		vbase   : `VBASE_RESET,
		pending : 13'h0001,
		default : '0
	};

	regs_t r;
	regs_t n;

	logic [2:0]  lvl;
	logic        irq_ok;
	logic [31:0] offset;
	logic [22:0] word_addr;
	logic        s_bit;

	// level seen by the core after two flops
	assign lvl    = r.irq_s2;
	assign s_bit  = r.sr[`SR_S_BIT];
	// level 7 cannot be masked
	assign irq_ok = (lvl > r.sr[`SR_MASK_LSB +: 3]) || (lvl == `MASK_TOP);
	// vector number times four, upper bits zero
	assign offset = {22'h000000, r.vector, 2'b00};
	// bit 0 never leaves: strobes stand for it
	assign word_addr = r.vaddr[`ADDR_W-1:1] + {21'h000000, r.word_cnt};

	// next state
	always_comb begin
		n = r;
		n.irq_s1       = irq_level;
		n.irq_s2       = r.irq_s1;
		n.avec_s1      = autovector;
		n.avec_s2      = r.avec_s1;
		n.vector_valid = 1'b0;
		n.resume       = 1'b0;
		n.load_ssp     = 1'b0;
		n.rdata        = 32'h0000_0000;

		// register writes
		if (reg_wr) begin
			if (reg_addr == `REG_SR) begin
				n.sr = reg_wdata[15:0];
			end else if (reg_addr == `REG_VBASE) begin
				if (`HAS_VBASE) begin
					n.vbase = reg_wdata;
				end
			end
		end

		// reads answer in the next cycle only
		if (reg_rd) begin
			if (reg_addr == `REG_SR) begin
				n.rdata = {16'h0000, r.sr};
			end else if (reg_addr == `REG_VBASE) begin
				n.rdata = r.vbase;
			end else if (reg_addr == `REG_STATUS) begin
				n.rdata = {3'h0, r.pending, r.vector, r.phase};
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end

		// normal references follow the core
		if (r.phase == PH_IDLE) begin
			n.bus.req    = core_ref_req;
			n.bus.write  = core_ref_write;
			n.bus.addr   = core_ref_addr[`ADDR_W-1:1];
			n.bus.strobe = 2'b11;
			if (core_ref_program) begin
				n.bus.space = s_bit ? `SPACE_SUP_PROG : `SPACE_USER_PROG;
			end else begin
				n.bus.space = s_bit ? `SPACE_SUP_DATA : `SPACE_USER_DATA;
			end
		end

		// sequencing; a clear inside a case item is undone below when
		// the same event arrives again in this cycle
		case (r.phase)
			PH_IDLE: begin
				n.is_irq   = 1'b0;
				n.is_reset = 1'b0;
				// group 0 first, any time
				if (r.pending[`P_RESET]) begin
					n.is_reset = 1'b1;
					n.vector   = `VEC_RESET;
					n.pending  = '0;
					n.phase    = PH_COPY;
				end else if (r.pending[`P_ADDR]) begin
					n.vector = `VEC_ADDR_ERR;
					n.pending[`P_ADDR] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_BERR]) begin
					n.vector = `VEC_BUS_ERR;
					n.pending[`P_BERR] = 1'b0;
					n.phase  = PH_COPY;
				end else if (instr_boundary && r.pending[`P_TRACE]) begin
					n.vector = `VEC_TRACE;
					n.pending[`P_TRACE] = 1'b0;
					n.phase  = PH_COPY;
				end else if (instr_boundary && irq_ok && lvl != 3'h0) begin
					n.is_irq  = 1'b1;
					n.irq_lvl = lvl;
					n.phase   = PH_COPY;
				end else if (instr_boundary && r.pending[`P_ILL]) begin
					n.vector = `VEC_ILLEGAL;
					n.pending[`P_ILL] = 1'b0;
					n.phase  = PH_COPY;
				end else if (instr_boundary && r.pending[`P_PRIV]) begin
					n.vector = `VEC_PRIV;
					n.pending[`P_PRIV] = 1'b0;
					n.phase  = PH_COPY;
				end else if (instr_boundary && r.pending[`P_LINEA]) begin
					n.vector = `VEC_LINE_A;
					n.pending[`P_LINEA] = 1'b0;
					n.phase  = PH_COPY;
				end else if (instr_boundary && r.pending[`P_LINEF]) begin
					n.vector = `VEC_LINE_F;
					n.pending[`P_LINEF] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_FMT]) begin
					n.vector = `VEC_FORMAT;
					n.pending[`P_FMT] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_ZDIV]) begin
					n.vector = `VEC_ZERO_DIV;
					n.pending[`P_ZDIV] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_BOUNDS]) begin
					n.vector = `VEC_BOUNDS;
					n.pending[`P_BOUNDS] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_OVF]) begin
					n.vector = `VEC_OVF_TRAP;
					n.pending[`P_OVF] = 1'b0;
					n.phase  = PH_COPY;
				end else if (r.pending[`P_TRAP]) begin
					n.vector = `VEC_TRAP_BASE + {4'h0, r.trap_n};
					n.pending[`P_TRAP] = 1'b0;
					n.phase  = PH_COPY;
				end
				if (n.phase == PH_COPY) begin
					n.bus.req = 1'b0;
				end
			end
			PH_COPY: begin
				// step one: keep the old status, enter supervisor
				n.sr_copy = r.sr;
				n.sr[`SR_S_BIT] = 1'b1;
				n.sr[`SR_T_BIT] = 1'b0;
				if (r.is_reset) begin
					n.sr[`SR_MASK_LSB +: 3] = `MASK_TOP;
				end else if (r.is_irq) begin
					n.sr[`SR_MASK_LSB +: 3] = r.irq_lvl;
				end
				if (r.is_irq) begin
					// acknowledge cycle, level on address bits 3..1
					n.bus.req    = 1'b1;
					n.bus.write  = 1'b0;
					n.bus.space  = `SPACE_CPU;
					n.bus.addr   = {20'hfffff, r.irq_lvl};
					n.bus.strobe = 2'b01;
					n.phase      = PH_ACK;
				end else begin
					n.phase = PH_ADDR;
				end
			end
			PH_ACK: begin
				// step two for interrupts: vector from outside
				if (bus_error) begin
					n.vector  = `VEC_SPURIOUS;
					n.bus.req = 1'b0;
					n.phase   = PH_ADDR;
				end else if (r.avec_s2) begin
					n.vector  = `VEC_SPURIOUS + {5'h00, r.irq_lvl};
					n.bus.req = 1'b0;
					n.phase   = PH_ADDR;
				end else if (bus_done) begin
					// upper byte is don't care; an unprogrammed source
					// answers its own uninitialised number
					n.vector  = bus_rdata[7:0];
					n.bus.req = 1'b0;
					n.phase   = PH_ADDR;
				end
			end
			PH_ADDR: begin
				// base is zero unless software moved the table
				n.vaddr        = r.vbase + offset;
				n.vector_valid = 1'b1;
				n.word_cnt     = 2'h0;
				n.fetch        = '0;
				// reset saves nothing
				n.phase    = r.is_reset ? PH_FETCH : PH_SAVE;
				n.save_req = ~r.is_reset;
			end
			PH_SAVE: begin
				// step three: core stacks the old context
				if (save_done) begin
					n.save_req = 1'b0;
					n.phase    = PH_FETCH;
				end
			end
			PH_FETCH: begin
				// step four: read the vector words
				n.bus.req    = 1'b1;
				n.bus.write  = 1'b0;
				n.bus.strobe = 2'b11;
				n.bus.addr   = word_addr;
				if (r.is_reset) begin
					n.bus.space = `SPACE_SUP_PROG;
				end else begin
					n.bus.space = `SPACE_SUP_DATA;
				end
				if (r.bus.req && bus_error) begin
					// fault while fetching a vector: give up
					n.bus.req = 1'b0;
					n.phase   = PH_HALT;
				end else if (r.bus.req && bus_done) begin
					n.fetch   = {r.fetch[47:0], bus_rdata};
					n.bus.req = 1'b0;
					if (r.word_cnt == (r.is_reset ? `RESET_LAST : `VECTOR_LAST)) begin
						n.phase = PH_DONE;
					end else begin
						n.word_cnt = r.word_cnt + 2'h1;
					end
				end
			end
			PH_DONE: begin
				// resume at the handler
				n.resume   = 1'b1;
				n.load_ssp = r.is_reset;
				n.phase    = PH_IDLE;
			end
			PH_HALT: begin
				// only a reset brings the unit back
				n.bus.req = 1'b0;
			end
			default: begin
				n.phase = PH_HALT;
			end
		endcase

		// events latch after the clears above, so a set wins
		if (soft_reset) begin
			n.pending[`P_RESET] = 1'b1;
			if (r.phase == PH_HALT) begin
				n.phase = PH_IDLE;
			end
		end
		if (odd_fetch) begin
			n.pending[`P_ADDR] = 1'b1;
		end
		if (bus_fault) begin
			n.pending[`P_BERR] = 1'b1;
		end
		if (instr_done && r.sr[`SR_T_BIT]) begin
			n.pending[`P_TRACE] = 1'b1;
		end
		if (illegal_op) begin
			n.pending[`P_ILL] = 1'b1;
		end
		if (priv_violation) begin
			n.pending[`P_PRIV] = 1'b1;
		end
		if (unimpl_op) begin
			if (opcode_top == `OP_LINE_A) begin
				n.pending[`P_LINEA] = 1'b1;
			end else begin
				n.pending[`P_LINEF] = 1'b1;
			end
		end
		// without a table base the number stays unused
		if (format_error && `HAS_VBASE) begin
			n.pending[`P_FMT] = 1'b1;
		end
		if (zero_divide) begin
			n.pending[`P_ZDIV] = 1'b1;
		end
		if (bounds_fail) begin
			n.pending[`P_BOUNDS] = 1'b1;
		end
		if (overflow_trap) begin
			n.pending[`P_OVF] = 1'b1;
		end
		if (trap_req) begin
			n.pending[`P_TRAP] = 1'b1;
			n.trap_n = trap_num;
		end

		// codes 0, 3 and 4 are never put out
		if (n.bus.space == 3'h0 || n.bus.space == 3'h3 || n.bus.space == 3'h4) begin
			n.bus.space = `SPACE_SUP_DATA;
		end
	end

	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= RESET_STATE;
		end else begin
			r <= n;
		end
	end

	// all outputs straight from the state register
	assign reg_rdata      = r.rdata;
	assign bus            = r.bus;
	assign save_req       = r.save_req;
	assign exc_active     = (r.phase != PH_IDLE);
	assign halted         = (r.phase == PH_HALT);
	assign vector_number  = r.vector;
	assign vector_valid   = r.vector_valid;
	assign vector_address = r.vaddr;
	assign status         = r.sr;
	assign status_copy    = r.sr_copy;
	assign resume         = r.resume;
	assign load_ssp       = r.load_ssp;
	assign new_pc         = r.fetch[31:0];
	assign new_ssp        = r.fetch[63:32];

endmodule : exception_vector_address_unit

// ===== src/exc_vec_cfg.svh
`ifndef EXC_VEC_CFG_SVH
`define EXC_VEC_CFG_SVH

// space codes, lowest code first
`define SPACE_USER_DATA 3'h1
`define SPACE_USER_PROG 3'h2
`define SPACE_SUP_DATA  3'h5
`define SPACE_SUP_PROG  3'h6
`define SPACE_CPU       3'h7
// vector numbers
`define VEC_RESET     8'h00
`define VEC_BUS_ERR   8'h02
`define VEC_ADDR_ERR  8'h03
`define VEC_ILLEGAL   8'h04
`define VEC_ZERO_DIV  8'h05
`define VEC_BOUNDS    8'h06
`define VEC_OVF_TRAP  8'h07
`define VEC_PRIV      8'h08
`define VEC_TRACE     8'h09
`define VEC_LINE_A    8'h0a
`define VEC_LINE_F    8'h0b
`define VEC_FORMAT    8'h0e
`define VEC_SPURIOUS  8'h18
`define VEC_TRAP_BASE 8'h20
`define OP_LINE_A     4'ha
// address layout
`define ADDR_W        24
`define TABLE_MASK    32'h0000_03ff
`define HAS_VBASE     1'b1
`define VBASE_RESET   32'h0000_0000
// register offsets
`define REG_SR        4'h0
`define REG_VBASE     4'h4
`define REG_STATUS    4'h8
// status register fields and reset value
`define SR_T_BIT      15
`define SR_S_BIT      13
`define SR_MASK_LSB   8
`define SR_RESET      16'h2700
`define MASK_TOP      3'h7
// last word index of a vector fetch
`define RESET_LAST    2'h3
`define VECTOR_LAST   2'h1
// pending event bits
`define PEND_W        13
`define P_RESET       0
`define P_ADDR        1
`define P_BERR        2
`define P_TRACE       3
`define P_ILL         4
`define P_PRIV        5
`define P_LINEA       6
`define P_LINEF       7
`define P_FMT         8
`define P_ZDIV        9
`define P_BOUNDS      10
`define P_OVF         11
`define P_TRAP        12
`endif

// ===== src/exc_vec_pkg.sv
package exc_vec_pkg;
	typedef enum logic [7:0] {
		PH_IDLE  = 8'h01,
		PH_COPY  = 8'h02,
		PH_ACK   = 8'h04,
		PH_ADDR  = 8'h08,
		PH_SAVE  = 8'h10,
		PH_FETCH = 8'h20,
		PH_DONE  = 8'h40,
		PH_HALT  = 8'h80
	} phase_t;

	// one bus reference as seen by the bus controller
	typedef struct packed {
		logic        req;
		logic        write;
		logic [2:0]  space;
		logic [22:0] addr;
		logic [1:0]  strobe;
	} bus_out_t;

	// everything the unit remembers
	typedef struct packed {
		phase_t      phase;
		logic [15:0] sr;
		logic [15:0] sr_copy;
		logic [31:0] vbase;
		logic [12:0] pending;
		logic [7:0]  vector;
		logic [31:0] vaddr;
		logic [1:0]  word_cnt;
		logic        is_irq;
		logic        is_reset;
		logic [2:0]  irq_lvl;
		logic [3:0]  trap_n;
		logic [2:0]  irq_s1;
		logic [2:0]  irq_s2;
		logic        avec_s1;
		logic        avec_s2;
		logic [63:0] fetch;
		bus_out_t    bus;
		logic        save_req;
		logic        vector_valid;
		logic        resume;
		logic        load_ssp;
		logic [31:0] rdata;
	} regs_t;
endpackage : exc_vec_pkg

// ===== tb/exc_vec_sva.sv
`timescale 1ns/10ps
module exc_vec_sva
	import exc_vec_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        core_ref_req,
	input wire logic        core_ref_program,
	input wire bus_out_t    bus,
	input wire logic        save_req,
	input wire logic        halted,
	input wire logic        exc_active,
	input wire logic [7:0]  vector_number,
	input wire logic        vector_valid,
	input wire logic [31:0] vector_address,
	input wire logic [15:0] status,
	input wire logic        resume,
	input wire logic        load_ssp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [31:0] base;
	// shadow of the table base; written in any phase, like the unit's own table base register
	always_ff @(posedge clk or negedge nrst)
		if (!nrst) base <= 32'h0;
		else if (reg_wr && reg_addr == 4'h4) base <= reg_wdata;

	property p_space_legal;
		bus.req |-> bus.space inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
	endproperty
	a_space_legal: assert property (p_space_legal)
		else $error("reserved space code");
	property p_idle_class;
		!exc_active && $past(!exc_active && core_ref_req) |-> bus.req &&
			bus.space == {$past(status[13]), $past(core_ref_program), !$past(core_ref_program)};
	endproperty
	a_idle_class: assert property (p_idle_class)
		else $error("wrong reference class");
	property p_ack;
		bus.req && bus.space == 3'h7 |-> bus.addr[22:3] == 20'hfffff && bus.strobe == 2'h1;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bad acknowledge cycle");
	property p_vaddr;
		vector_valid |=> vector_address == base + {22'h0, vector_number, 2'h0};
	endproperty
	a_vaddr: assert property (p_vaddr)
		else $error("wrong vector address");
	property p_fetch_space;
		exc_active && bus.req && bus.space != 3'h7 |->
			bus.space == (vector_number == 8'h0 ? 3'h6 : 3'h5) && bus.strobe == 2'h3;
	endproperty
	a_fetch_space: assert property (p_fetch_space)
		else $error("wrong fetch space");
	property p_fetch_addr;
		exc_active && bus.req && bus.space != 3'h7 |->
			({bus.addr, 1'b0} - vector_address[23:0]) < (vector_number == 8'h0 ? 24'h8 : 24'h4);
	endproperty
	a_fetch_addr: assert property (p_fetch_addr)
		else $error("fetch outside vector");
	property p_save_order;
		$rose(save_req) |-> vector_valid;
	endproperty
	a_save_order: assert property (p_save_order)
		else $error("save before vector");
	property p_save_quiet;
		save_req |-> !bus.req;
	endproperty
	a_save_quiet: assert property (p_save_quiet)
		else $error("fetch during save");
	property p_done_bound;
		$fell(save_req) |-> ##[1:24] resume;
	endproperty
	a_done_bound: assert property (p_done_bound)
		else $error("no resume after save");
	property p_entry;
		resume |-> status[13] && !status[15];
	endproperty
	a_entry: assert property (p_entry)
		else $error("status not set up");
	property p_reset_ctx;
		load_ssp |-> resume && status[10:8] == 3'h7;
	endproperty
	a_reset_ctx: assert property (p_reset_ctx)
		else $error("bad reset context");
	property p_halt_quiet;
		halted |-> !bus.req && !save_req && !resume;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet)
		else $error("activity while halted");
endmodule : exc_vec_sva

// ===== tb/exc_bus_model.sv
`timescale 1ns/10ps
module exc_bus_model
	import exc_vec_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire bus_out_t   bus,
	input  wire logic [1:0] lat,
	input  wire logic [7:0] ack_vec,
	input  wire logic       ack_berr,
	output logic            bus_done,
	output logic            bus_error,
	output logic [15:0]     bus_rdata
);
	logic [1:0] cnt;
	// one answer per request after lat waits; idle data toggles so stale bytes never match
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 2'h0;
			bus_done <= 1'b0;
			bus_error <= 1'b0;
			bus_rdata <= 16'h0;
		end else begin
			bus_done <= 1'b0;
			bus_error <= 1'b0;
			bus_rdata <= ~bus_rdata;
			if (bus.req && !bus_done && !bus_error) begin
				cnt <= cnt + 2'h1;
				if (cnt == lat) begin
					cnt <= 2'h0;
					// an armed error answers every space, so a vector fetch can fault too
					bus_done <= !ack_berr;
					bus_error <= ack_berr;
					// number on the low byte, junk above
					bus_rdata <= bus.space == 3'h7 ? {~ack_vec, ack_vec} : bus.addr[15:0] ^ 16'h3c5a;
				end
			end
		end
	end
endmodule : exc_bus_model

// ===== tb/test_exception_vector_address_unit.sv
`timescale 1ns/10ps
module test_exception_vector_address_unit
	import exc_vec_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        core_ref_req = 1'b0;
	logic        core_ref_write = 1'b0;
	logic        core_ref_program = 1'b0;
	logic [23:0] core_ref_addr = 24'h000400;
	logic        instr_boundary = 1'b1;
	logic        instr_done = 1'b0;
	logic        save_done = 1'b0;
	logic [10:0] ev = 11'h0;
	logic [3:0]  opcode_top = 4'hf;
	logic [3:0]  trap_num = 4'h0;
	logic [2:0]  irq_level = 3'h0;
	logic        autovector = 1'b0;
	logic [1:0]  lat = 2'h0;
	logic [7:0]  ack_vec = 8'h40;
	logic        ack_berr = 1'b0;
	logic [31:0] base = 32'h0;
	logic        bus_done, bus_error, save_req, exc_active, vector_valid, resume, load_ssp;
	logic        halted;
	logic [15:0] bus_rdata, status, status_copy;
	logic [31:0] reg_rdata, vector_address, new_pc, new_ssp;
	logic [7:0]  vector_number;
	bus_out_t    bus;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	// event bit and the vector it must raise
	int          eb[12] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 8, 9, 9};
	logic [7:0]  evx[12] = '{8'h03, 8'h02, 8'h04, 8'h0a, 8'h0b, 8'h08, 8'h0e, 8'h05, 8'h06,
		8'h07, 8'h20, 8'h2f};
	logic [7:0]  ivx[4] = '{8'h40, 8'h1d, 8'h18, 8'hff};
	logic [2:0]  ilv[4] = '{3'h3, 3'h5, 3'h2, 3'h7};

	exception_vector_address_unit dut (
		.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.core_ref_req, .core_ref_write, .core_ref_program, .core_ref_addr,
		.instr_boundary, .instr_done, .soft_reset(ev[10]), .odd_fetch(ev[0]),
		.bus_fault(ev[1]), .illegal_op(ev[2]), .unimpl_op(ev[3]), .opcode_top,
		.priv_violation(ev[4]), .format_error(ev[5]), .zero_divide(ev[6]),
		.bounds_fail(ev[7]), .overflow_trap(ev[8]), .trap_req(ev[9]), .trap_num,
		.save_done, .bus_done, .bus_error, .bus_rdata, .irq_level, .autovector,
		.bus, .save_req, .exc_active, .halted, .vector_number, .vector_valid,
		.vector_address, .status, .status_copy, .resume, .load_ssp, .new_pc, .new_ssp);
	exc_bus_model far (.clk, .nrst, .bus, .lat, .ack_vec, .ack_berr, .bus_done, .bus_error,
		.bus_rdata);

	always #25 clk = ~clk;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("MISMATCH %0t timeout", $time);
			summarize();
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [15:0] m(input logic [22:0] w);
		return w[15:0] ^ 16'h3c5a;
	endfunction : m
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk) reg_wr <= 1'b0;
		if (a == 4'h4) base = d;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk) reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk) reg_rd <= 1'b0;
		@(negedge clk) chk(reg_rdata, e);
		// read data stand for one cycle only
		@(negedge clk) chk(reg_rdata, 32'h0);
	endtask : rd
	task pulse(input int b);
		@(posedge clk) ev[b] <= 1'b1;
		@(posedge clk) ev[b] <= 1'b0;
	endtask : pulse
	// bounded wait: 0 vector, 1 save request, 2 resume
	task wt(input int k);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((k == 0 ? vector_valid : k == 1 ? save_req : resume) !== 1'b1 && n < 60);
		if (n == 60) chk(32'h0, 32'h1);
	endtask : wt
	// follow one exception to its resume; the request pin drops once acknowledged
	task go(input logic [7:0] v, input logic [15:0] sx);
		logic [31:0] a;
		logic [22:0] w;
		a = base + {22'h0, v, 2'h0};
		w = v == 8'h0 ? 23'h2 : a[23:1];
		if (v != 8'h0) begin
			wt(0);
			@(negedge clk) chk(vector_number, v);
			chk(vector_address, a);
			@(posedge clk) irq_level <= 3'h0;
			ack_berr <= 1'b0;
			wt(1);
			@(posedge clk) save_done <= 1'b1;
			@(posedge clk) save_done <= 1'b0;
		end
		wt(2);
		chk(new_pc, {m(w), m(w + 23'h1)});
		chk(status, sx);
		chk(exc_active, 32'h0);
		chk(load_ssp, v == 8'h0);
		if (v == 8'h0) chk(new_ssp, {m(23'h0), m(23'h1)});
	endtask : go
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		go(8'h00, 16'h2700);
		rd(4'h4, 32'h0);
		rd(4'hc, 32'h0);
		rd(4'h0, 32'h0000_2700);
		rd(4'h8, 32'h0000_0001);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {18'h0, i[1], 13'h0});
			@(posedge clk) core_ref_req <= 1'b1;
			core_ref_program <= i[0];
			core_ref_write <= i[1];
			repeat (2) @(posedge clk);
			@(negedge clk) chk(bus.space, {i[1], i[0], ~i[0]});
			chk({bus.write, bus.addr}, {i[1], 23'h000200});
			@(posedge clk) core_ref_req <= 1'b0;
		end
		$display("space test done");
		for (int i = 0; i < 12; i++) begin
			if (i == 10) wr(4'h4, 32'h12ff_fc00);
			wr(4'h0, 32'h0);
			lat <= i[1:0];
			opcode_top <= i == 3 ? 4'ha : 4'hf;
			trap_num <= i == 10 ? 4'h0 : 4'hf;
			pulse(eb[i]);
			go(evx[i], 16'h2000);
		end
		$display("internal vector test done");
		wr(4'h0, 32'h8000);
		@(posedge clk) instr_done <= 1'b1;
		@(posedge clk) instr_done <= 1'b0;
		go(8'h09, 16'h2000);
		chk(status_copy, 16'h8000);
		$display("trace test done");
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, i == 3 ? 32'h0700 : 32'h0);
			ack_vec <= i == 3 ? 8'hff : 8'h40;
			ack_berr <= i == 2;
			autovector <= i == 1;
			irq_level <= ilv[i];
			go(ivx[i], {5'h4, ilv[i], 8'h0});
			@(posedge clk) autovector <= 1'b0;
			ack_berr <= 1'b0;
		end
		$display("interrupt test done");
		wr(4'h4, 32'h0);
		wr(4'h0, 32'h0);
		// a faulting reset fetch must stop the unit until the next reset
		ack_berr <= 1'b1;
		pulse(10);
		repeat (16) @(posedge clk);
		@(negedge clk) chk(halted, 32'h1);
		@(posedge clk) ack_berr <= 1'b0;
		pulse(10);
		go(8'h00, 16'h2700);
		chk(halted, 32'h0);
		$display("soft reset test done");
		// hardware reset mid-run must drop a moved table base
		wr(4'h4, 32'h0000_1000);
		@(posedge clk) nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		base = 32'h0;
		go(8'h00, 16'h2700);
		rd(4'h4, 32'h0);
		$display("hardware reset test done");
		summarize();
	end
endmodule : test_exception_vector_address_unit

bind exception_vector_address_unit exc_vec_sva chk (.clk, .nrst, .reg_addr, .reg_wdata,
	.reg_wr, .core_ref_req, .core_ref_program, .bus, .save_req, .halted, .exc_active,
	.vector_number, .vector_valid, .vector_address, .status, .resume, .load_ssp);
